// ===== core/smmd_pkg.sv
// Functional notes
// - 256 KB: four 64 KB segments, 16 KB pages
// - Code and data share one decoded map
// - Word: low byte even, high byte odd
// - Double word is two ascending words
// - Bit 0 even LSB, bit 15 odd MSB
// - Low 8 KB: ROM, else external when disabled
// - 02000h-0F9FFh and segments 1-3 external
// - 0FA00h-0FDFFh internal RAM, register bank anywhere
// - 0FE00h-0FFFFh register area, no fetches
// - 00000h-000BFh vector table reserved
// - Stack words 0FA00h to 0FBFEh
// - 0FDE0h-0FDFFh event transfer pointers
// - Bit access: 0FF00h-0FFDFh, 0FD00h-0FDFFh, bank
// - Internal storage only in segment 0
// - ROM enabled only when both config pins 0
package smmd_pkg;
    localparam int ADDR_W = 18;
    localparam int BANK_BYTES = 32;
    localparam logic [1:0] SEG_INTERNAL = 2'h0;
    localparam logic [15:0] ROM_LO = 16'h0000;
    localparam logic [15:0] ROM_HI = 16'h1FFF;
    localparam logic [15:0] RAM_LO = 16'hFA00;
    localparam logic [15:0] RAM_HI = 16'hFDFF;
    localparam logic [15:0] SFR_LO = 16'hFE00;
    localparam logic [15:0] SFR_HI = 16'hFFFF;
    localparam logic [15:0] VEC_HI = 16'h00BF;
    localparam logic [15:0] STACK_LO = 16'hFA00;
    localparam logic [15:0] STACK_HI = 16'hFBFE;
    localparam logic [15:0] PTR_LO = 16'hFDE0;
    localparam logic [15:0] PTR_HI = 16'hFDFF;
    localparam logic [15:0] BITR_LO = 16'hFD00;
    localparam logic [15:0] BITR_HI = 16'hFDFF;
    localparam logic [15:0] BITS_LO = 16'hFF00;
    localparam logic [15:0] BITS_HI = 16'hFFDF;
    localparam logic [15:0] BANK_INIT = 16'hFC00;
    localparam logic ROM_EN_RESET = 1'b0;
    typedef enum logic [3:0]
    {
        SMMD_ROM = 4'h1,
        SMMD_EXT = 4'h2,
        SMMD_RAM = 4'h4,
        SMMD_SFR = 4'h8
    } smmd_region_t;
endpackage

// ===== core/smmd_rom_latch.sv
`timescale 1ns/1ps
// Catches the ROM enable state from the config pins while reset is held
module smmd_rom_latch
(
    input  wire logic i_mclk,
    input  wire logic i_reset_n,
    input  wire logic i_bus_config_pin_high,
    input  wire logic i_bus_config_pin_low,
    output logic      o_rom_enable
);
    logic sync_a;
    logic sync_b;
    logic capture;

    // Two-stage sampling, free running so the strap is seen during reset
    // Limitation: reset must be held for at least two clocks
    always_ff @(posedge i_mclk)
    begin
        sync_a <= i_bus_config_pin_high | i_bus_config_pin_low;
        sync_b <= sync_a;
    end

    // One-shot capture on the first edge after release; strap then frozen
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            capture <= 1'h1;
        else
            capture <= 1'h0;
    end

    // Enabled only with both pins low
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_rom_enable <= smmd_pkg::ROM_EN_RESET;
        else if (capture)
            o_rom_enable <= ~sync_b;
    end
endmodule

// ===== core/smmd_lane.sv
`timescale 1ns/1ps
// Little-endian byte lanes and bit order of a word access
module smmd_lane
(
    input  wire logic        i_addr0,
    input  wire logic        i_word,
    output logic             o_lane_lo,
    output logic             o_lane_hi,
    output logic             o_misaligned
);
    // Low byte on even address, high byte on next odd one
    // Bit 0 is even LSB, bit 15 odd MSB on the 16-bit path
    assign o_lane_lo    = i_word ? 1'b1 : ~i_addr0;
    assign o_lane_hi    = i_word ? 1'b1 : i_addr0;
    assign o_misaligned = i_word & i_addr0;
endmodule

// ===== core/smmd_decoder.sv
`timescale 1ns/1ps
// Segmented memory map decoder for core and event controller masters
module smmd_decoder
(
    input  wire logic        i_mclk,
    input  wire logic        i_reset_n,
    input  wire logic        i_bus_config_pin_high,
    input  wire logic        i_bus_config_pin_low,
    input  wire logic        i_req,
    input  wire logic [17:0] i_addr,
    input  wire logic        i_word,
    input  wire logic        i_fetch,
    input  wire logic        i_bit_access,
    input  wire logic        i_event_xfer,
    input  wire logic [15:0] i_context_pointer,
    output logic             o_valid,
    output logic [17:0]      o_addr,
    output logic             o_sel_rom,
    output logic             o_sel_ext,
    output logic             o_sel_ram,
    output logic             o_sel_sfr,
    output logic             o_lane_lo,
    output logic             o_lane_hi,
    output logic             o_vector_area,
    output logic             o_stack_area,
    output logic             o_pointer_area,
    output logic             o_bank_area,
    output logic             o_fault,
    output logic             o_rom_enable
);
    logic                     rom_enable;
    logic                     lane_lo;
    logic                     lane_hi;
    logic                     misaligned;
    logic [15:0]              offs;
    logic                     seg0;
    smmd_pkg::smmd_region_t   next_region;
    logic                     bank_hit;
    logic                     bit_ok;
    logic                     next_fault;
    logic                     vec_hit;
    logic                     stack_hit;
    logic                     ptr_hit;

    smmd_rom_latch u_rom_latch
    (
        .i_mclk                (i_mclk),
        .i_reset_n             (i_reset_n),
        .i_bus_config_pin_high (i_bus_config_pin_high),
        .i_bus_config_pin_low  (i_bus_config_pin_low),
        .o_rom_enable          (rom_enable)
    );

    smmd_lane u_lane
    (
        .i_addr0      (i_addr[0]),
        .i_word       (i_word),
        .o_lane_lo    (lane_lo),
        .o_lane_hi    (lane_hi),
        .o_misaligned (misaligned)
    );

    // Inclusive window compare, shared by all area tests except vector and bank
    function automatic logic in_range
    (
        input logic [15:0] a,
        input logic [15:0] lo,
        input logic [15:0] hi
    );
        in_range = (a >= lo) && (a <= hi);
    endfunction

    // Segment in bits 17:16, page in 15:14 of one linear space
    assign offs = i_addr[15:0];
    assign seg0 = (i_addr[17:16] == smmd_pkg::SEG_INTERNAL);

    // Active bank spans 32 bytes from the context pointer
    assign bank_hit = (offs >= i_context_pointer)
                   && ({1'b0, offs} < ({1'b0, i_context_pointer} + 17'(smmd_pkg::BANK_BYTES)));

    // Region pick, one select only; fetch and data use same map
    always_comb
    begin
        next_region = smmd_pkg::SMMD_EXT;
        if (seg0)
        begin
            if (in_range(offs, smmd_pkg::ROM_LO, smmd_pkg::ROM_HI))
                next_region = rom_enable ? smmd_pkg::SMMD_ROM : smmd_pkg::SMMD_EXT;
            else if (in_range(offs, smmd_pkg::RAM_LO, smmd_pkg::RAM_HI))
                next_region = smmd_pkg::SMMD_RAM;
            else if (in_range(offs, smmd_pkg::SFR_LO, smmd_pkg::SFR_HI))
                next_region = smmd_pkg::SMMD_SFR;
        end
    end

    // Bit access only in three windows
    assign bit_ok = seg0 && (in_range(offs, smmd_pkg::BITS_LO, smmd_pkg::BITS_HI)
                          || in_range(offs, smmd_pkg::BITR_LO, smmd_pkg::BITR_HI)
                          || bank_hit);

    // Fetch from register area, bad bit access, odd word are flagged
    // Software must keep words in one area; odd word caught as a hint
    always_comb
    begin
        next_fault = 1'b0;
        if (i_fetch && next_region == smmd_pkg::SMMD_SFR)
            next_fault = 1'b1;
        if (i_bit_access && !bit_ok)
            next_fault = 1'b1;
        if (misaligned)
            next_fault = 1'b1;
    end

    // Reserved sub-area hits; markers only
    // They never change which region is selected
    assign vec_hit   = seg0 && (offs <= smmd_pkg::VEC_HI);
    assign stack_hit = seg0 && !i_addr[0]
                    && in_range(offs, smmd_pkg::STACK_LO, smmd_pkg::STACK_HI);
    assign ptr_hit   = seg0 && in_range(offs, smmd_pkg::PTR_LO, smmd_pkg::PTR_HI);

    // Answer strobe one cycle after each taken request
    // Not held: a master that stalls must repeat its request
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_valid <= 1'h0;
        end
        else
        begin
            o_valid <= i_req;
        end
    end

    // Linear 18-bit byte address, segment in the top two bits
    // Copied every edge, so only meaningful beside o_valid
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_addr <= 18'h00000;
        end
        else
        begin
            o_addr <= i_addr;
        end
    end

    // ROM select, only with the strap latched as enabled
    // Fetch and data share this map, no separate code path
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_sel_rom <= 1'h0;
        end
        else
        begin
            o_sel_rom <= i_req && (next_region == smmd_pkg::SMMD_ROM);
        end
    end

    // External select: rest of segment 0 and segments 1 to 3
    // Also takes the low 8 KB when the strap disabled the ROM
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_sel_ext <= 1'h0;
        end
        else
        begin
            o_sel_ext <= i_req && (next_region == smmd_pkg::SMMD_EXT);
        end
    end

    // Internal RAM select; only segment 0 maps internal storage
    // Register bank, stack and pointers all live inside this window
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_sel_ram <= 1'h0;
        end
        else
        begin
            o_sel_ram <= i_req && (next_region == smmd_pkg::SMMD_RAM);
        end
    end

    // Register area select; fetches from it are flagged
    // The select still goes out so a bad fetch can be traced
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_sel_sfr <= 1'h0;
        end
        else
        begin
            o_sel_sfr <= i_req && (next_region == smmd_pkg::SMMD_SFR);
        end
    end

    // Low lane: even byte, or the lower half of a word
    // Word low byte sits at the even address
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_lane_lo <= 1'h0;
        end
        else
        begin
            o_lane_lo <= i_req && lane_lo;
        end
    end

    // High lane: odd byte, or the upper half of a word
    // Bits 15 to 8 of a word travel on this lane
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_lane_hi <= 1'h0;
        end
        else
        begin
            o_lane_hi <= i_req && lane_hi;
        end
    end

    // Fault flag, raised again by every offending request
    // Advisory only: it never blocks the select beside it
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_fault <= 1'h0;
        end
        else
        begin
            o_fault <= i_req && next_fault;
        end
    end

    // Trap and interrupt vector table marker
    // Set whether the low area is ROM or external
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_vector_area <= 1'h0;
        end
        else
        begin
            o_vector_area <= i_req && vec_hit;
        end
    end

    // Stack window marker, even word addresses only
    // An odd byte inside the window is not a stack word
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_stack_area <= 1'h0;
        end
        else
        begin
            o_stack_area <= i_req && stack_hit;
        end
    end

    // Event transfer pointer marker, top 32 bytes of RAM
    // Marked for every master, as the core sets up pointers too
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_pointer_area <= 1'h0;
        end
        else
        begin
            o_pointer_area <= i_req && ptr_hit;
        end
    end

    // Active register bank marker inside RAM
    // Double words arrive as two word requests, each marked
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_bank_area <= 1'h0;
        end
        else
        begin
            o_bank_area <= i_req && bank_hit && (next_region == smmd_pkg::SMMD_RAM);
        end
    end

    // Latched strap, frozen until the next reset
    assign o_rom_enable = rom_enable;
endmodule

// ===== tb/smmd_decoder_props.sv
`timescale 1ns/1ps
// Decode relations, each answer one cycle after its request
module smmd_decoder_props
(
    input wire logic        i_mclk,
    input wire logic        i_reset_n,
    input wire logic        i_req,
    input wire logic [17:0] i_addr,
    input wire logic        i_word,
    input wire logic        i_fetch,
    input wire logic        o_valid,
    input wire logic [17:0] o_addr,
    input wire logic        o_sel_rom,
    input wire logic        o_sel_ext,
    input wire logic        o_sel_ram,
    input wire logic        o_sel_sfr,
    input wire logic        o_lane_lo,
    input wire logic        o_lane_hi,
    input wire logic        o_pointer_area,
    input wire logic        o_fault,
    input wire logic        o_rom_enable
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    // Only segment 0 holds internal storage
    sequence s_seg0; i_req && i_addr[17:16] == 2'h0; endsequence
    property p_answer; i_req |=> o_valid && o_addr == $past(i_addr); endproperty
    a_answer: assert property (p_answer) else $error("answer missing");
    property p_one; o_valid |-> $onehot({o_sel_rom, o_sel_ext, o_sel_ram, o_sel_sfr}); endproperty
    a_one: assert property (p_one) else $error("select not one hot");
    property p_ram; s_seg0 ##0 i_addr[15:0] inside {[16'hFA00:16'hFDFF]} |=> o_sel_ram; endproperty
    a_ram: assert property (p_ram) else $error("ram select");
    property p_sfr; s_seg0 ##0 i_addr[15:9] == 7'h7F |=> o_sel_sfr; endproperty
    a_sfr: assert property (p_sfr) else $error("register area select");
    property p_code; s_seg0 ##0 i_fetch && i_addr[15:9] == 7'h7F |=> o_fault; endproperty
    a_code: assert property (p_code) else $error("fetch not flagged");
    property p_high; i_req && i_addr[17:16] != 2'h0 |=> o_sel_ext; endproperty
    a_high: assert property (p_high) else $error("upper segment select");
    property p_mid; i_req && i_addr >= 18'h02000 && i_addr <= 18'h0F9FF |=> o_sel_ext; endproperty
    a_mid: assert property (p_mid) else $error("external select");
    property p_rom;
        s_seg0 ##0 i_addr[15:13] == 3'h0 ##1 $stable(o_rom_enable) |-> o_sel_rom == o_rom_enable;
    endproperty
    a_rom: assert property (p_rom) else $error("low area select");
    property p_word; i_req && i_word |=> o_lane_lo && o_lane_hi; endproperty
    a_word: assert property (p_word) else $error("word lanes");
    property p_odd; i_req && !i_word && i_addr[0] |=> o_lane_hi && !o_lane_lo; endproperty
    a_odd: assert property (p_odd) else $error("odd byte lane");
    property p_ptr; s_seg0 ##0 i_addr[15:5] == 11'h7EF |=> o_pointer_area; endproperty
    a_ptr: assert property (p_ptr) else $error("pointer area");
endmodule
bind smmd_decoder smmd_decoder_props smmd_decoder_props_inst (.*);

// ===== tb/smmd_master_model.sv
`timescale 1ns/1ps
// Bus master issuing one-cycle requests
module smmd_master_model
(
    input  wire logic   i_mclk,
    output logic        o_req,
    output logic [17:0] o_addr,
    output logic        o_word,
    output logic        o_fetch
);
    initial {o_req, o_addr, o_word, o_fetch} = '0;
    // Request held over exactly one edge, then released
    task automatic access(input logic [17:0] a, input logic w, input logic f);
        @(posedge i_mclk);
        #1;
        o_req = 1'b1;
        o_addr = w ? {a[17:1], 1'b0} : a; // Word units kept even
        o_word = w;
        o_fetch = f;
        @(posedge i_mclk);
        #1;
        o_req = 1'b0;
        o_addr = ~o_addr; // Released bus must not look valid
    endtask
endmodule

// ===== tb/smmd_decoder_tb_top.sv
`timescale 1ns/1ps
module smmd_decoder_tb_top;
    logic i_mclk = 0, i_reset_n = 0, pin_hi = 0, pin_lo = 0;
    logic [15:0] cp = 16'hFC00;
    logic req, word, fetch, valid, rom_en, lo, hi, vec, stk, ptr, bank, fault;
    logic bit_acc = 1'h0;
    logic [17:0] addr, oaddr;
    logic [3:0] sel;
    int miscompares = 0, total_checks = 0, cycles = 0;
    always #4 i_mclk = ~i_mclk;
    smmd_master_model smmd_master_model_inst (.i_mclk(i_mclk), .o_req(req), .o_addr(addr),
        .o_word(word), .o_fetch(fetch));
    smmd_decoder smmd_decoder_inst (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
        .i_bus_config_pin_high(pin_hi), .i_bus_config_pin_low(pin_lo), .i_req(req),
        .i_addr(addr), .i_word(word), .i_fetch(fetch), .i_bit_access(bit_acc),
        .i_event_xfer(1'b0), .i_context_pointer(cp), .o_valid(valid), .o_addr(oaddr),
        .o_sel_rom(sel[0]), .o_sel_ext(sel[1]), .o_sel_ram(sel[2]), .o_sel_sfr(sel[3]),
        .o_lane_lo(lo), .o_lane_hi(hi), .o_vector_area(vec), .o_stack_area(stk),
        .o_pointer_area(ptr), .o_bank_area(bank), .o_fault(fault), .o_rom_enable(rom_en));
    task automatic complete_run;
        if (miscompares == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [17:0] e, input logic [17:0] g);
        total_checks++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask
    task automatic go(input logic [17:0] a, input logic w, input logic f);
        smmd_master_model_inst.access(a, w, f);
    endtask
    // Pins are only looked at while reset is held
    task automatic do_reset(input logic h, input logic l);
        i_reset_n = 0;
        pin_hi = h;
        pin_lo = l;
        repeat (8) @(posedge i_mclk);
        #1 i_reset_n = 1;
        repeat (4) @(posedge i_mclk);
        #1;
    endtask
    task automatic t_strap;
        for (int k = 0; k < 4; k++)
        begin
            do_reset(k[1], k[0]);
            chk("rom_enable", k == 0, rom_en);
            go(18'h01FFE, 1, 1);
            chk("low_region", (k == 0) ? 4'h1 : 4'h2, sel);
        end
        // Strap must stay frozen when the pins move after reset
        do_reset(0, 0);
        pin_hi = 1;
        pin_lo = 1;
        go(18'h00000, 0, 1);
        chk("rom_hold", 1, rom_en);
        chk("low_hold", 4'h1, sel);
    endtask
    task automatic t_map;
        logic [17:0] a [10] = '{18'h000BF, 18'h02000, 18'h0F9FF, 18'h0FA00, 18'h0FDFF,
            18'h0FE00, 18'h0FFFF, 18'h10000, 18'h3FFFF, 18'h1FA00};
        logic [3:0] e [10] = '{4'h1, 4'h2, 4'h2, 4'h4, 4'h4, 4'h8, 4'h8, 4'h2, 4'h2, 4'h2};
        for (int i = 0; i < 10; i++)
        begin
            go(a[i], 0, 0);
            chk("region", e[i], sel);
            chk("addr", a[i], oaddr);
            chk("valid", 1, valid);
        end
    endtask
    task automatic t_lanes;
        go(18'h0FA00, 1, 0);
        chk("word_lanes", 2'h3, {hi, lo});
        go(18'h0FA01, 0, 0);
        chk("odd_lane", 2'h2, {hi, lo});
        go(18'h0FA02, 0, 0);
        chk("even_lane", 2'h1, {hi, lo});
    endtask
    task automatic t_areas;
        cp = 16'hFA20;
        go(18'h0FA3E, 1, 0);
        chk("bank_in", 1, bank);
        go(18'h0FA40, 1, 0);
        chk("bank_out", 0, bank);
        go(18'h0FDE0, 0, 0);
        chk("ptr_in", 1, ptr);
        go(18'h0FDDF, 0, 0);
        chk("ptr_out", 0, ptr);
        go(18'h000BF, 0, 0);
        chk("vec_in", 1, vec);
        go(18'h000C0, 0, 0);
        chk("vec_out", 0, vec);
        go(18'h0FBFE, 1, 0);
        chk("stack_in", 1, stk);
        go(18'h0FC00, 1, 0);
        chk("stack_out", 0, stk);
        go(18'h0FE00, 1, 1);
        chk("sfr_fetch", 1, fault);
        go(18'h0FA00, 1, 1);
        chk("ram_fetch", 0, fault);
    endtask
    // Bit accesses inside and outside the three bit windows
    task automatic t_bits;
        cp = 16'hFA20;
        bit_acc = 1'h1;
        go(18'h0FF00, 0, 0);
        chk("bit_sfr_in", 0, fault);
        go(18'h0FFE0, 0, 0);
        chk("bit_sfr_out", 1, fault);
        go(18'h0FD00, 1, 0);
        chk("bit_ram_in", 0, fault);
        go(18'h0FA22, 1, 0);
        chk("bit_bank_in", 0, fault);
        go(18'h0FA00, 1, 0);
        chk("bit_bank_out", 1, fault);
        go(18'h1FF00, 0, 0);
        chk("bit_upper_seg", 1, fault);
        bit_acc = 1'h0;
    endtask
    // Generous ceiling over roughly 150 cycles of traffic
    always @(posedge i_mclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            complete_run();
        end
    end
    initial
    begin
        t_strap();
        do_reset(0, 0);
        t_map();
        t_lanes();
        t_areas();
        t_bits();
        complete_run();
    end
endmodule
